// ==== src/mmd_decode.sv ====
// Memory map decoder with info block lock and bit-band translation.
// Assumes one request per cycle held until reqDone; memories answer in
// the same cycle as a forwarded access (single-cycle SRAM port).
`timescale 1ns/1ps
`default_nettype none
module mmd_decode (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Master request
   input wire logic reqValid,
   input wire logic [31:0] reqAddr,
   input wire logic reqWrite,
   input wire logic [31:0] reqWdata,
   input wire logic reqFetch,
   input wire logic reqFromCore,
   input wire logic reqPriv,
   input wire logic reqIbus,
   // Configuration
   input wire logic eccEnable,
   input wire logic [103:0] serialNumber,
   input wire logic ctrlWrite,
   input wire logic [31:0] ctrlWdata,
   // SRAM port
   input wire logic [31:0] sramRdata,
   output logic sramValid,
   output logic sramWrite,
   output logic [31:0] sramAddr,
   output logic [31:0] sramWdata,
   // Answer and routing
   output logic reqDone,
   output logic reqError,
   output logic [31:0] reqRdata,
   output logic [7:0] target,
   output logic infoUnlocked
);
   mmd_lock_if lk ();
   mmd_lock mmd_lock_inst (.sys_clk(sys_clk), .rst_n(rst_n), .lk(lk));
   assign lk.wrValid = ctrlWrite;
   assign lk.wrData = ctrlWdata;

   logic [31:0] sramEnd;
   logic inSram, inAlias, inInfo, inFlash, inCode, inApb, inPeri, inPpb;
   mmd_pkg::mmd_tgt_e tgt;
   logic [4:0] bitIdx;
   logic [31:0] bitWord;
   logic [2:0] snIdx;
   logic [31:0] snWord;
   logic [103:0] snSh;

   // Usable SRAM shrinks when upper banks hold check bits
   assign sramEnd = eccEnable ? mmd_pkg::SRAM_END_ECC
                              : mmd_pkg::SRAM_END_RAW;
   assign inSram = reqAddr >= mmd_pkg::SRAM_BASE && reqAddr <= sramEnd;
   assign inAlias = reqAddr >= mmd_pkg::ALIAS_BASE &&
                    reqAddr <= mmd_pkg::ALIAS_END;
   assign inInfo = reqAddr >= mmd_pkg::INFO_BASE &&
                   reqAddr <= mmd_pkg::INFO_END;
   assign inFlash = reqAddr >= mmd_pkg::FLASH_BASE &&
                    reqAddr <= mmd_pkg::FLASH_END;
   assign inCode = reqAddr <= mmd_pkg::CODE_END;
   assign inApb = reqAddr >= mmd_pkg::APB_BASE &&
                  reqAddr <= mmd_pkg::APB_END;
   assign inPeri = reqAddr >= mmd_pkg::APB_BASE &&
                   reqAddr <= mmd_pkg::PERI_END;
   assign inPpb = reqAddr >= mmd_pkg::PPB_BASE &&
                  reqAddr <= mmd_pkg::PPB_END;

   // Alias word to primary word and bit: byte offset*8 + bit
   assign bitIdx = reqAddr[6:2];
   assign bitWord = mmd_pkg::SRAM_BASE + {12'h000, reqAddr[24:7], 2'b00};

   // Serial number words, unused bits read as zero
   assign snIdx = reqAddr[4:2];
   assign snSh = serialNumber;
   always_comb begin
      case (snIdx)
         3'h0: snWord = snSh[31:0] & mmd_pkg::SN_W0_MSK;
         3'h1: snWord = {1'b0, snSh[mmd_pkg::SN_W1_LO +: 31]};
         3'h2: snWord = {15'h0000, snSh[mmd_pkg::SN_W2_LO +: 17]};
         3'h3: snWord = {1'b0, snSh[mmd_pkg::SN_W3_LO +: 31]};
         3'h4: snWord = {24'h00_0000, snSh[mmd_pkg::SN_W4_LO +: 8]};
         default: snWord = 32'h0000_0000;
      endcase
   end

   // Region choice; refusals for PPB, alias and locked info
   always_comb begin
      tgt = mmd_pkg::TGT_ERR;
      if (inInfo) begin
         if (lk.unlocked && !reqWrite) begin
            tgt = mmd_pkg::TGT_INFO;
         end
      end else if (inFlash || inCode) begin
         if (reqIbus || !reqWrite) begin
            tgt = mmd_pkg::TGT_ICACHE;
         end
      end else if (inSram) begin
         tgt = mmd_pkg::TGT_SRAM;
      end else if (inAlias) begin
         tgt = reqFromCore ? mmd_pkg::TGT_SRAM
                           : mmd_pkg::TGT_ERR;
      end else if (inApb) begin
         tgt = mmd_pkg::TGT_APB;
      end else if (inPeri) begin
         tgt = mmd_pkg::TGT_AHBP;
      end else if (inPpb) begin
         if (reqFromCore && reqPriv) begin
            tgt = mmd_pkg::TGT_PPB;
         end
      end
   end

   // Transaction sequencer
   mmd_pkg::mmd_bb_e st_r, st_nxt;
   logic sramValid_nxt, sramWrite_nxt, reqDone_nxt, reqError_nxt;
   logic [31:0] sramAddr_nxt, sramWdata_nxt, reqRdata_nxt;
   logic [7:0] target_nxt;
   logic aliasOp_r, aliasOp_nxt;
   logic [4:0] bit_r, bit_nxt;
   logic bitVal_r, bitVal_nxt;

   always_comb begin
      st_nxt = st_r;
      sramValid_nxt = 1'b0;
      sramWrite_nxt = 1'b0;
      sramAddr_nxt = sramAddr;
      sramWdata_nxt = sramWdata;
      reqDone_nxt = 1'b0;
      reqError_nxt = 1'b0;
      reqRdata_nxt = reqRdata;
      target_nxt = target;
      aliasOp_nxt = aliasOp_r;
      bit_nxt = bit_r;
      bitVal_nxt = bitVal_r;
      case (st_r)
         mmd_pkg::BB_IDLE: begin
            if (reqValid) begin
               target_nxt = tgt;
               if (tgt == mmd_pkg::TGT_SRAM) begin
                  aliasOp_nxt = inAlias;
                  bit_nxt = bitIdx;
                  bitVal_nxt = reqWdata[0];
                  sramValid_nxt = 1'b1;
                  // Alias: always read first, for read or RMW
                  sramWrite_nxt = reqWrite && !inAlias;
                  sramAddr_nxt = inAlias ? bitWord : reqAddr;
                  sramWdata_nxt = reqWdata;
                  st_nxt = mmd_pkg::BB_RD;
               end else begin
                  reqDone_nxt = 1'b1;
                  reqError_nxt = tgt == mmd_pkg::TGT_ERR;
                  reqRdata_nxt = tgt == mmd_pkg::TGT_INFO ? snWord
                                                          : 32'h0000_0000;
                  st_nxt = mmd_pkg::BB_DONE;
               end
            end
         end
         mmd_pkg::BB_RD: begin
            if (aliasOp_r && reqWrite) begin
               sramValid_nxt = 1'b1;
               sramWrite_nxt = 1'b1;
               sramWdata_nxt = sramRdata;
               sramWdata_nxt[bit_r] = bitVal_r;
               st_nxt = mmd_pkg::BB_WR;
            end else begin
               reqDone_nxt = 1'b1;
               reqRdata_nxt = aliasOp_r ? {31'h0, sramRdata[bit_r]}
                                        : sramRdata;
               st_nxt = mmd_pkg::BB_DONE;
            end
         end
         mmd_pkg::BB_WR: begin
            reqDone_nxt = 1'b1;
            st_nxt = mmd_pkg::BB_DONE;
         end
         mmd_pkg::BB_DONE: begin
            st_nxt = mmd_pkg::BB_IDLE; // Master drops request meanwhile
         end
         default: st_nxt = mmd_pkg::BB_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= mmd_pkg::BB_IDLE;
         sramValid <= 1'b0;
         sramWrite <= 1'b0;
         sramAddr <= 32'h0000_0000;
         sramWdata <= 32'h0000_0000;
         reqDone <= 1'b0;
         reqError <= 1'b0;
         reqRdata <= 32'h0000_0000;
         target <= mmd_pkg::TGT_NONE;
         aliasOp_r <= 1'b0;
         bit_r <= 5'h00;
         bitVal_r <= 1'b0;
         infoUnlocked <= 1'b0;
      end else begin
         st_r <= st_nxt;
         sramValid <= sramValid_nxt;
         sramWrite <= sramWrite_nxt;
         sramAddr <= sramAddr_nxt;
         sramWdata <= sramWdata_nxt;
         reqDone <= reqDone_nxt;
         reqError <= reqError_nxt;
         reqRdata <= reqRdata_nxt;
         target <= target_nxt;
         aliasOp_r <= aliasOp_nxt;
         bit_r <= bit_nxt;
         bitVal_r <= bitVal_nxt;
         infoUnlocked <= lk.unlocked;
      end
   end
endmodule : mmd_decode
`default_nettype wire

// ==== src/mmd_pkg.sv ====
// Package for the memory map decode and lock block.
// Assumes a single 50 MHz system clock domain; no software registers.
// Functional notes
// - Unlock only after words 3A7F5CA3, A1E34F20, 9608B2C1 written in order.
// - Unlocked info block reads only; serial number read from 0x1080_0000.
// - Any other 32-bit control write relocks the info block; here an out-of-order UNLOCK_W1/W2 write only restarts the sequence.
// - Serial number is 104 bits; bits 7:0 hold the die revision.
// - SRAM is 160KB without ECC, 128KB with ECC enabled.
// - Each alias word from 0x2200_0000 maps to one primary SRAM bit.
// - Alias read returns one bit; alias write sets or clears that bit.
// - Alias read becomes primary read; alias write becomes read-modify-write.
// - Non-core alias access does no bit operation and gets bus error.
// - Instruction fetches from SRAM go over system bus, bypassing cache.
// - Instruction cache of 16384 bytes serves instruction-bus flash fetches.
// - Range 0x4000_0000 to 0x400F_FFFF goes through the peripheral bridge.
// - Private peripheral range accepts only core accesses; others refused.
// - Private peripheral access allowed only in privileged mode.
// - Space 0x4000_0000 to 0x5FFF_FFFF decodes to module registers and buffers.
// - With ECC on, upper SRAM banks hold check bits, leaving the map.
package mmd_pkg;
   localparam logic [31:0] UNLOCK_W0 = 32'h3A7F_5CA3;
   localparam logic [31:0] UNLOCK_W1 = 32'hA1E3_4F20;
   localparam logic [31:0] UNLOCK_W2 = 32'h9608_B2C1;
   localparam logic [31:0] INFO_BASE = 32'h1080_0000;
   localparam logic [31:0] INFO_END = 32'h1080_3FFF;
   localparam logic [31:0] FLASH_BASE = 32'h1000_0000;
   localparam logic [31:0] FLASH_END = 32'h1005_FFFF;
   localparam logic [31:0] CODE_END = 32'h1FFF_FFFF;
   localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
   localparam logic [31:0] SRAM_END_RAW = 32'h2002_7FFF;
   localparam logic [31:0] SRAM_END_ECC = 32'h2001_FFFF;
   localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
   localparam logic [31:0] ALIAS_END = 32'h23FF_FFFF;
   localparam logic [31:0] APB_BASE = 32'h4000_0000;
   localparam logic [31:0] APB_END = 32'h400F_FFFF;
   localparam logic [31:0] PERI_END = 32'h5FFF_FFFF;
   localparam logic [31:0] PPB_BASE = 32'hE000_0000;
   localparam logic [31:0] PPB_END = 32'hE00F_FFFF;
   localparam int ICACHE_BYTES = 16384;
   localparam int SN_BITS = 104;
   localparam int SN_REV_MSB = 7;
   localparam int SN_WORDS = 5;
   localparam logic [2:0] SN_IDX_W = 3'h5;
   // Serial number word layout by address word index
   localparam logic [31:0] SN_W0_MSK = 32'h0001_FFFF;
   localparam int SN_W1_LO = 17;
   localparam int SN_W2_LO = 48;
   localparam int SN_W3_LO = 65;
   localparam int SN_W4_LO = 96;
   // Target select, one-hot
   typedef enum logic [7:0] {
      TGT_NONE = 8'h01,
      TGT_ICACHE = 8'h02,
      TGT_INFO = 8'h04,
      TGT_SRAM = 8'h08,
      TGT_APB = 8'h10,
      TGT_AHBP = 8'h20,
      TGT_PPB = 8'h40,
      TGT_ERR = 8'h80
   } mmd_tgt_e;
   // Bit-band sequencer states
   typedef enum logic [3:0] {
      BB_IDLE = 4'h1,
      BB_RD = 4'h2,
      BB_WR = 4'h4,
      BB_DONE = 4'h8
   } mmd_bb_e;
endpackage : mmd_pkg

// ==== src/mmd_lock_if.sv ====
// Interface between the decoder and its lock tracker.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface mmd_lock_if;
   logic wrValid;
   logic [31:0] wrData;
   logic unlocked;
   modport tracker (input wrValid, input wrData, output unlocked);
   modport user (output wrValid, output wrData, input unlocked);
endinterface : mmd_lock_if
`default_nettype wire

// ==== src/mmd_lock.sv ====
// Unlock sequence tracker for the information block.
// Assumes one write pulse per accepted 32-bit control write.
`timescale 1ns/1ps
`default_nettype none
module mmd_lock (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Decoder side
   mmd_lock_if.tracker lk
);
   logic [1:0] step_r, step_nxt;
   logic open_r, open_nxt;

   // Sequence walk; a stray UNLOCK_W1/W2 only restarts, any word that is no unlock word restarts and relocks
   always_comb begin
      step_nxt = step_r;
      open_nxt = open_r;
      if (lk.wrValid) begin
         if (lk.wrData == mmd_pkg::UNLOCK_W0) begin
            step_nxt = 2'h1;
         end else if (lk.wrData == mmd_pkg::UNLOCK_W1 && step_r == 2'h1) begin
            step_nxt = 2'h2;
         end else if (lk.wrData == mmd_pkg::UNLOCK_W2 && step_r == 2'h2) begin
            step_nxt = 2'h0;
            open_nxt = 1'b1;
         end else if (lk.wrData == mmd_pkg::UNLOCK_W1 ||
                      lk.wrData == mmd_pkg::UNLOCK_W2) begin
            step_nxt = 2'h0; // Out of order: restart, lock state kept
         end else begin
            step_nxt = 2'h0;
            open_nxt = 1'b0;
         end
      end
   end

   // Locked from reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         step_r <= 2'h0;
         open_r <= 1'b0;
      end else begin
         step_r <= step_nxt;
         open_r <= open_nxt;
      end
   end

   assign lk.unlocked = open_r;
endmodule : mmd_lock
`default_nettype wire

// ==== verif/mmd_decode_monitor.sv ====
// Checker for the memory map decoder, bound to its top module.
// Assumes one request per rise of reqValid, held until reqDone.
`timescale 1ns/1ps
`default_nettype none
module mmd_decode_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Request and configuration
   input wire logic reqValid,
   input wire logic [31:0] reqAddr,
   input wire logic reqWrite,
   input wire logic [31:0] reqWdata,
   input wire logic reqFromCore,
   input wire logic reqPriv,
   input wire logic eccEnable,
   input wire logic ctrlWrite,
   input wire logic [31:0] ctrlWdata,
   // Answers
   input wire logic [31:0] sramRdata,
   input wire logic sramValid,
   input wire logic sramWrite,
   input wire logic [31:0] sramAddr,
   input wire logic [31:0] sramWdata,
   input wire logic reqDone,
   input wire logic reqError,
   input wire logic [7:0] target,
   input wire logic infoUnlocked
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ****************
   // Alias translation, routing and lock checks
   // ****************
   logic inAlias;
   logic [31:0] word;
   logic [4:0] bitIx;
   // Word and bit that an alias address stands for
   assign inAlias = reqAddr[31:25] == 7'h11;
   assign word = {12'h200, reqAddr[24:7], 2'b00};
   assign bitIx = reqAddr[6:2];
   sequence s_rd;
      sramValid && !sramWrite && sramAddr == word;
   endsequence
   // Only the addressed bit may differ from what was read
   sequence s_rmw;
      sramValid && sramWrite && sramAddr == word &&
      sramWdata[bitIx] == reqWdata[0] &&
      ((sramWdata ^ $past(sramRdata)) & ~(32'h0000_0001 << bitIx)) == 32'h0;
   endsequence
   a_alias_rmw_steps: assert property (
      $rose(reqValid) && inAlias && reqFromCore && reqWrite
      |-> ##1 s_rd ##1 s_rmw ##1 (reqDone && !reqError))
      else $error("alias write steps wrong");
   a_alias_read_step: assert property (
      $rose(reqValid) && inAlias && reqFromCore && !reqWrite
      |-> ##1 s_rd ##1 (reqDone && !reqError))
      else $error("alias read steps wrong");
   a_alias_dma_err: assert property (
      $rose(reqValid) && inAlias && !reqFromCore
      |-> ##1 (reqDone && reqError && !sramValid) ##1 !sramValid)
      else $error("non-core alias not refused");
   a_ppb_refused: assert property (
      $rose(reqValid) && reqAddr[31:20] == 12'hE00 &&
      !(reqFromCore && reqPriv) |-> ##1 (reqDone && reqError))
      else $error("private area access not refused");
   a_ppb_accepted: assert property (
      $rose(reqValid) && reqAddr[31:20] == 12'hE00 && reqFromCore &&
      reqPriv |-> ##1 (reqDone && !reqError && target == 8'h40))
      else $error("privileged core access refused");
   a_ecc_sram_limit: assert property (
      $rose(reqValid) && eccEnable && reqAddr[31:15] == 17'h4004
      |-> ##1 (reqDone && reqError))
      else $error("check bank reachable with ECC on");
   a_bridge_route: assert property (
      $rose(reqValid) && reqAddr[31:20] == 12'h400
      |-> ##1 (reqDone && target == 8'h10))
      else $error("bridge range misrouted");
   a_info_locked: assert property (
      $rose(reqValid) && reqAddr[31:14] == 18'h0_4200 && !infoUnlocked
      |-> ##1 (reqDone && reqError))
      else $error("locked info block accessed");
   a_relock_write: assert property (
      ctrlWrite && ctrlWdata != mmd_pkg::UNLOCK_W0 &&
      ctrlWdata != mmd_pkg::UNLOCK_W1 &&
      ctrlWdata != mmd_pkg::UNLOCK_W2 |-> ##2 !infoUnlocked)
      else $error("info block stayed unlocked");
   a_unlock_cause: assert property (
      $rose(infoUnlocked)
      |-> $past(ctrlWrite && ctrlWdata == mmd_pkg::UNLOCK_W2, 2))
      else $error("unlock without final word");
endmodule : mmd_decode_monitor
bind mmd_decode mmd_decode_monitor mmd_decode_monitor_inst (.*);
`default_nettype wire

// ==== verif/mmd_sram_model.sv ====
// Behavioural system SRAM that answers the decoder's SRAM port.
// Assumes read data is wanted while sramValid stands; 256 words only.
`timescale 1ns/1ps
`default_nettype none
module mmd_sram_model (
   // Clock
   input wire logic sys_clk,
   // Port from the decoder
   input wire logic sramValid,
   input wire logic sramWrite,
   input wire logic [31:0] sramAddr,
   input wire logic [31:0] sramWdata,
   output var logic [31:0] sramRdata
);
   logic [31:0] mem [0:255];
   // Cleared array so read-modify-write never meets unknowns
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 32'h0000_0000;
      end
   end
   // Read data stands in the strobe's own cycle, as the sequencer samples
   // it at the edge that ends that cycle; otherwise the inverse is shown,
   // so stale data never looks valid
   always_comb begin
      if (sramValid && !sramWrite) begin
         sramRdata = mem[sramAddr[9:2]];
      end else begin
         sramRdata = ~mem[sramAddr[9:2]];
      end
   end
   // Writes land at the edge that ends the strobe cycle
   always @(posedge sys_clk) begin
      if (sramValid && sramWrite) begin
         mem[sramAddr[9:2]] <= sramWdata;
      end
   end
endmodule : mmd_sram_model
`default_nettype wire

// ==== verif/test_memory_map_decode_lock.sv ====
// Self-checking bench for the memory map decoder.
// Assumes the SRAM model answers the decoder's SRAM port.
`timescale 1ns/1ps
`default_nettype none
module test_memory_map_decode_lock;
   localparam logic [103:0] SN = 104'hA5_1C3E_5F70_9B2D_4E6A_8C01_37F9;
   localparam logic [31:0] Z = 32'h0000_0000;
   // Master flags: core, privileged, instruction bus, fetch
   localparam logic [3:0] CP = 4'hC, CU = 4'h8, DM = 4'h0;
   localparam logic [3:0] IF = 4'hB, SF = 4'hD;
   logic sys_clk, rst_n, reqValid, reqWrite, reqFetch, reqFromCore;
   logic reqPriv, reqIbus, eccEnable, ctrlWrite, sramValid, sramWrite;
   logic reqDone, reqError, infoUnlocked, rErr;
   logic [31:0] reqAddr, reqWdata, ctrlWdata, sramRdata, sramAddr;
   logic [31:0] sramWdata, reqRdata, rData;
   logic [103:0] serialNumber;
   logic [7:0] target, rTgt;
   int miscompares, checksDone;
   mmd_decode mmd_decode_inst (.*);
   mmd_sram_model mmd_sram_model_inst (.*);
   // **************
   // Shared tasks
   // **************
   task automatic chk(input string n, input logic [31:0] e, g);
      checksDone++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic ce(input string n, input logic e);
      chk(n, {31'h0, e}, {31'h0, rErr});
   endtask : ce
   task automatic ct(input string n, input logic [7:0] e);
      chk(n, {24'h0, e}, {24'h0, rTgt});
   endtask : ct
   // Request held until reqDone, then one idle cycle for DONE
   task automatic rq(input logic [31:0] a, input logic w,
                     input logic [31:0] d, input logic [3:0] f);
      reqAddr = a;
      reqWrite = w;
      reqWdata = d;
      {reqFromCore, reqPriv, reqIbus, reqFetch} = f;
      reqValid = 1'b1;
      repeat (8) begin
         @(posedge sys_clk);
         #1;
         if (reqDone === 1'b1) break;
      end
      chk("done", 32'h1, {31'h0, reqDone});
      rErr = reqError;
      rData = reqRdata;
      rTgt = target;
      reqValid = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask : rq
   task automatic ctrl(input logic [31:0] d);
      ctrlWrite = 1'b1;
      ctrlWdata = d;
      @(posedge sys_clk);
      #1;
      ctrlWrite = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask : ctrl
   // **************
   // Scenarios
   // **************
   task automatic t_lock;
      rq(32'h1080_0000, 1'b0, Z, CP);
      ce("locked read", 1'b1);
      ctrl(mmd_pkg::UNLOCK_W0);
      ctrl(mmd_pkg::UNLOCK_W1);
      ctrl(mmd_pkg::UNLOCK_W2);
      @(posedge sys_clk);
      #1;
      chk("unlocked", 32'h1, {31'h0, infoUnlocked});
      rq(32'h1080_0000, 1'b0, Z, CP);
      chk("serial w0", {15'h0, SN[16:0]}, rData);
      rq(32'h1080_0004, 1'b0, Z, CP);
      chk("serial w1", {1'h0, SN[47:17]}, rData);
      rq(32'h1080_0008, 1'b0, Z, CP);
      chk("serial w2", {15'h0, SN[64:48]}, rData);
      rq(32'h1080_000C, 1'b0, Z, CP);
      chk("serial w3", {1'h0, SN[95:65]}, rData);
      rq(32'h1080_0010, 1'b0, Z, CP);
      chk("serial w4", {24'h0, SN[103:96]}, rData);
      rq(32'h1080_0000, 1'b1, Z, CP);
      ce("info write", 1'b1);
      ctrl(Z);
      @(posedge sys_clk);
      #1;
      rq(32'h1080_0000, 1'b0, Z, CP);
      ce("relocked", 1'b1);
   endtask : t_lock
   task automatic t_sram;
      rq(32'h2000_0004, 1'b1, 32'h1234_5678, CP);
      rq(32'h2000_0004, 1'b0, Z, SF);
      chk("sram fetch", 32'h1234_5678, rData);
      ct("fetch route", mmd_pkg::TGT_SRAM);
      eccEnable = 1'b1;
      rq(32'h2001_FFFC, 1'b0, Z, CP);
      ce("ecc top", 1'b0);
      rq(32'h2002_0000, 1'b0, Z, CP);
      ce("check bank", 1'b1);
      eccEnable = 1'b0;
      rq(32'h2002_7FFC, 1'b0, Z, CP);
      ce("raw top", 1'b0);
      rq(32'h2002_8000, 1'b0, Z, CP);
      ce("past sram", 1'b1);
   endtask : t_sram
   // Clear bit 4, set bit 31, set bit 0 of the next word
   task automatic t_alias;
      rq(32'h2000_0000, 1'b1, 32'h0000_00F0, CP);
      rq(32'h2200_0010, 1'b1, Z, CP);
      rq(32'h2200_007C, 1'b1, 32'h0000_0001, CP);
      rq(32'h2200_0080, 1'b1, 32'h0000_0001, CP);
      rq(32'h2000_0000, 1'b0, Z, CP);
      chk("clear set", 32'h8000_00E0, rData);
      rq(32'h2000_0004, 1'b0, Z, CP);
      chk("next word", 32'h1234_5679, rData);
      rq(32'h2200_0014, 1'b0, Z, CP);
      chk("alias one", 32'h0000_0001, rData);
      rq(32'h2200_0010, 1'b0, Z, CP);
      chk("alias zero", Z, rData);
      rq(32'h2200_0014, 1'b1, Z, DM);
      ce("dma alias", 1'b1);
      rq(32'h2000_0000, 1'b0, Z, CP);
      chk("dma no op", 32'h8000_00E0, rData);
   endtask : t_alias
   task automatic t_route;
      rq(32'hE000_E010, 1'b0, Z, CP);
      ct("ppb priv", mmd_pkg::TGT_PPB);
      rq(32'hE000_E010, 1'b0, Z, CU);
      ce("ppb user", 1'b1);
      rq(32'hE00F_FFFC, 1'b0, Z, DM);
      ce("ppb dma", 1'b1);
      rq(32'h400F_FFFC, 1'b0, Z, DM);
      ct("bridge", mmd_pkg::TGT_APB);
      rq(32'h5FFF_FFFC, 1'b0, Z, CP);
      ct("periph top", mmd_pkg::TGT_AHBP);
      rq(32'h1000_0000, 1'b0, Z, IF);
      ct("flash fetch", mmd_pkg::TGT_ICACHE);
      rq(32'h6000_0000, 1'b0, Z, CP);
      ce("unmapped", 1'b1);
   endtask : t_route
   // Unlock, then a reset in mid-run must leave the block locked
   task automatic t_reset;
      ctrl(mmd_pkg::UNLOCK_W0);
      ctrl(mmd_pkg::UNLOCK_W1);
      ctrl(mmd_pkg::UNLOCK_W2);
      @(posedge sys_clk);
      #1;
      chk("pre reset", 32'h1, {31'h0, infoUnlocked});
      rst_n = 1'b0;
      @(posedge sys_clk);
      #1;
      chk("reset lock", Z, {31'h0, infoUnlocked});
      rst_n = 1'b1;
      rq(32'h1080_0000, 1'b0, Z, CP);
      ce("reset read", 1'b1);
   endtask : t_reset
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run
   // 20 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Watchdog far beyond the hundred or so cycles the tests need
   initial begin
      repeat (3000) @(posedge sys_clk);
      miscompares++;
      complete_run;
   end
   // Reset for 10 cycles, then the scenarios
   initial begin
      rst_n = 1'b0;
      {reqValid, reqWrite, reqFetch, reqFromCore} = 4'h0;
      {reqPriv, reqIbus, eccEnable, ctrlWrite} = 4'h0;
      {reqAddr, reqWdata, ctrlWdata} = {Z, Z, Z};
      serialNumber = SN;
      repeat (10) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      t_lock;
      t_sram;
      t_alias;
      t_route;
      t_reset;
      complete_run;
   end
endmodule : test_memory_map_decode_lock
`default_nettype wire
